//--- hdl/fault_limit_pkg.sv
// Constants shared by the output fault limit and response logic
package fault_limit_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_SENSE_GAIN = 8'h38;
    localparam logic [7:0] CMD_SENSE_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OV_THRESHOLD = 8'h40;
    localparam logic [7:0] CMD_OV_RESPONSE = 8'h41;
    localparam logic [7:0] CMD_UV_THRESHOLD = 8'h44;
    localparam logic [7:0] CMD_UV_RESPONSE = 8'h45;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] SENSE_GAIN_RST = 16'hba2a;
    localparam logic [15:0] SENSE_OFFSET_RST = 16'hbe00;
    localparam logic [15:0] THRESHOLD_RST = 16'h0000;
    localparam logic [7:0] RESPONSE_RST = 8'h80;

    ////////////////////////////////////////////////////////////////////////////////
    // Response byte fields
    localparam int BEH_HI = 7;
    localparam int BEH_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int TIME_HI = 2;
    localparam int TIME_LO = 0;
    localparam logic [1:0] BEH_IGNORE = 2'h0;
    localparam logic [1:0] BEH_DELAY_OFF = 2'h1;
    localparam logic [1:0] BEH_OFF_NOW = 2'h2;
    localparam logic [1:0] BEH_HOLD_OFF = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up threshold scaling, fixed point with SCALE_SHIFT fraction bits
    localparam int SCALE_SHIFT = 10;
    localparam logic [10:0] OV_SCALE = 11'h49a;
    localparam logic [10:0] UV_SCALE = 11'h366;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int OV_UNIT_US = 1;
    localparam int UV_UNIT_US = 10;
    localparam int OV_TICK_CYCLES = OV_UNIT_US * CLK_MHZ;
    localparam int UV_TICK_CYCLES = UV_UNIT_US * CLK_MHZ;
    localparam int PRESCALE_W = 12;

endpackage

//--- hdl/sync_2ff.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module sync_2ff
    import fault_limit_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (ce_i) begin
            s_d.meta = d_i;
            s_d.stable = s_q.meta;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.stable;

endmodule // sync_2ff

//--- hdl/fault_responder.sv
// Response sequencer for one voltage fault type
`timescale 1ns/10ps
module fault_responder
    import fault_limit_pkg::*;
#(
    parameter bit IGNORE_ALLOWED = 1'b1,
    parameter int TICK_CYCLES = 100
) (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic enable_i,
    input wire logic fault_i,
    input wire logic [7:0] response_i,
    input wire logic stop_retry_i,
    // Status
    output logic off_o,
    output logic shut_o
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_INTERVAL,
        ST_LATCHED,
        ST_HOLD
    } resp_state_t;

    typedef struct packed {
        resp_state_t state;
        logic [PRESCALE_W-1:0] prescale;
        logic [2:0] ticks;
        logic [2:0] used;
    } resp_t;

    localparam logic [PRESCALE_W-1:0] TICK_LAST = PRESCALE_W'(TICK_CYCLES - 1);

    resp_t r_q;
    resp_t r_d;
    logic [1:0] behaviour;
    logic [2:0] retry_cfg;
    logic [2:0] time_cfg;
    logic tick;
    logic go_off;
    logic retry_left;

    always_comb begin
        r_d = r_q;
        shut_o = 1'b0;
        go_off = 1'b0;
        tick = 1'b0;
        behaviour = response_i[BEH_HI:BEH_LO];
        retry_cfg = response_i[RETRY_HI:RETRY_LO];
        time_cfg = response_i[TIME_HI:TIME_LO];
        if (!IGNORE_ALLOWED && behaviour == BEH_IGNORE) begin
            behaviour = BEH_OFF_NOW;
        end
        retry_left = (retry_cfg == RETRY_FOREVER) || (r_q.used < retry_cfg);
        if (r_q.prescale == TICK_LAST) begin
            r_d.prescale = '0;
            tick = 1'b1;
        end else begin
            r_d.prescale = r_q.prescale + 1'b1;
        end
        case (r_q.state)
            ST_IDLE: begin
                r_d.prescale = '0;
                r_d.ticks = '0;
                if (fault_i) begin
                    case (behaviour)
                        BEH_DELAY_OFF: r_d.state = ST_DELAY;
                        BEH_OFF_NOW: go_off = 1'b1;
                        BEH_HOLD_OFF: begin
                            r_d.state = ST_HOLD;
                            shut_o = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            ST_DELAY: begin
                if (!fault_i) begin
                    r_d.state = ST_IDLE;
                end else if (r_q.ticks >= time_cfg) begin
                    go_off = 1'b1;
                end else if (tick) begin
                    r_d.ticks = r_q.ticks + 1'b1;
                end
            end
            ST_INTERVAL: begin
                if (stop_retry_i && retry_cfg == RETRY_FOREVER) begin
                    r_d.state = ST_LATCHED;
                end else if (r_q.ticks >= time_cfg) begin
                    r_d.state = ST_IDLE;
                    if (retry_cfg != RETRY_FOREVER) begin
                        r_d.used = r_q.used + 1'b1;
                    end
                end else if (tick) begin
                    r_d.ticks = r_q.ticks + 1'b1;
                end
            end
            ST_LATCHED: ;
            ST_HOLD: begin
                if (!fault_i) begin
                    r_d.state = ST_IDLE;
                end
            end
            default: r_d.state = ST_IDLE;
        endcase
        if (go_off) begin
            shut_o = 1'b1;
            r_d.ticks = '0;
            r_d.prescale = '0;
            r_d.state = retry_left ? ST_INTERVAL : ST_LATCHED;
        end
        // Dropping enable is the restart: it also ends an endless retry loop
        if (!enable_i) begin
            r_d.state = ST_IDLE;
            r_d.used = '0;
            shut_o = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= '{state: ST_IDLE, prescale: '0, ticks: '0, used: '0};
        end else if (ce_i) begin
            r_q <= r_d;
        end
    end

    assign off_o = (r_q.state == ST_INTERVAL) || (r_q.state == ST_LATCHED)
                   || (r_q.state == ST_HOLD);

endmodule // fault_responder

//--- hdl/output_fault_limit_response.sv
// Fault limit registers, command crossing and output fault response
`timescale 1ns/10ps
module output_fault_limit_response
    import fault_limit_pkg::*;
(
    // Core clock
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Link clock and command port
    input wire logic link_clk_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic cmd_busy_o,
    output logic cmd_done_o,
    output logic cmd_nack_o,
    output logic [15:0] cmd_rdata_o,
    // Converter side
    input wire logic [15:0] vout_target_i,
    input wire logic [15:0] vout_meas_i,
    input wire logic vout_meas_valid_i,
    input wire logic enable_i,
    input wire logic ramping_i,
    // Status
    output logic output_on_o,
    output logic ov_fault_o,
    output logic uv_fault_o,
    output logic [15:0] sense_gain_o,
    output logic [15:0] sense_offset_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [15:0] sense_gain;
        logic [15:0] sense_offset;
        logic [15:0] ov_threshold;
        logic [7:0] ov_response;
        logic [15:0] uv_threshold;
        logic [7:0] uv_response;
        logic init_done;
        logic ov_cond;
        logic uv_cond;
        logic ov_flag;
        logic uv_flag;
        logic out_on;
        logic req_seen;
        logic ack_tgl;
        logic [15:0] rsp_data;
        logic rsp_nack;
    } core_t;

    typedef struct packed {
        logic req_tgl;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
        logic busy;
        logic ack_seen;
        logic [15:0] rdata;
        logic nack;
        logic done;
    } link_t;

    core_t c_q;
    core_t c_d;
    link_t l_q;
    link_t l_d;
    logic link_rst;
    logic req_sync;
    logic ack_sync;
    logic ov_off;
    logic uv_off;
    logic ov_shut;
    logic uv_shut;
    logic clear_faults;
    logic [26:0] ov_prod;
    logic [26:0] uv_prod;
    logic [16:0] ov_scaled;
    logic [16:0] uv_scaled;

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings
    sync_2ff #(.WIDTH(1)) u_link_rst_sync (
        .clk_i(link_clk_i),
        .rst_i(1'b0),
        .ce_i(1'b1),
        .d_i(rst_i),
        .q_o(link_rst)
    );

    sync_2ff #(.WIDTH(1)) u_req_sync (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(l_q.req_tgl),
        .q_o(req_sync)
    );

    sync_2ff #(.WIDTH(1)) u_ack_sync (
        .clk_i(link_clk_i),
        .rst_i(link_rst),
        .ce_i(1'b1),
        .d_i(c_q.ack_tgl),
        .q_o(ack_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: holds one command stable until the core acknowledges it
    always_comb begin
        l_d = l_q;
        l_d.done = 1'b0;
        if (!l_q.busy && cmd_valid_i) begin
            l_d.write = cmd_write_i;
            l_d.code = cmd_code_i;
            l_d.wdata = cmd_wdata_i;
            l_d.req_tgl = ~l_q.req_tgl;
            l_d.busy = 1'b1;
        end
        // Core answer words are held still until the next request, so sampling is safe
        if (l_q.busy && ack_sync != l_q.ack_seen) begin
            l_d.ack_seen = ack_sync;
            l_d.rdata = c_q.rsp_data;
            l_d.nack = c_q.rsp_nack;
            l_d.done = 1'b1;
            l_d.busy = 1'b0;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign cmd_busy_o = l_q.busy;
    assign cmd_done_o = l_q.done;
    assign cmd_nack_o = l_q.nack;
    assign cmd_rdata_o = l_q.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up thresholds from the strapped target
    assign ov_prod = {11'h000, vout_target_i} * {16'h0000, OV_SCALE};
    assign uv_prod = {11'h000, vout_target_i} * {16'h0000, UV_SCALE};
    assign ov_scaled = ov_prod[SCALE_SHIFT +: 17];
    assign uv_scaled = uv_prod[SCALE_SHIFT +: 17];

    ////////////////////////////////////////////////////////////////////////////////
    // Fault responders
    fault_responder #(
        .IGNORE_ALLOWED(1'b0),
        .TICK_CYCLES(OV_TICK_CYCLES)
    ) u_ov_resp (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .enable_i(enable_i),
        .fault_i(c_q.ov_cond),
        .response_i(c_q.ov_response),
        .stop_retry_i(uv_shut),
        .off_o(ov_off),
        .shut_o(ov_shut)
    );

    fault_responder #(
        .IGNORE_ALLOWED(1'b1),
        .TICK_CYCLES(UV_TICK_CYCLES)
    ) u_uv_resp (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .enable_i(enable_i),
        .fault_i(c_q.uv_cond),
        .response_i(c_q.uv_response),
        .stop_retry_i(ov_shut),
        .off_o(uv_off),
        .shut_o(uv_shut)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain
    always_comb begin
        c_d = c_q;
        clear_faults = 1'b0;
        // Strap is read once, the first enabled cycle after reset release
        if (!c_q.init_done) begin
            c_d.init_done = 1'b1;
            c_d.ov_threshold = ov_scaled[16] ? 16'hffff : ov_scaled[15:0];
            c_d.uv_threshold = uv_scaled[16] ? 16'hffff : uv_scaled[15:0];
        end
        if (req_sync != c_q.req_seen) begin
            c_d.req_seen = req_sync;
            c_d.ack_tgl = ~c_q.ack_tgl;
            c_d.rsp_nack = 1'b0;
            c_d.rsp_data = 16'h0000;
            case (l_q.code)
                CMD_CLEAR_FAULTS: clear_faults = 1'b1;
                CMD_SENSE_GAIN: begin
                    c_d.rsp_data = c_q.sense_gain;
                    if (l_q.write) c_d.sense_gain = l_q.wdata;
                end
                CMD_SENSE_OFFSET: begin
                    c_d.rsp_data = c_q.sense_offset;
                    if (l_q.write) c_d.sense_offset = l_q.wdata;
                end
                CMD_OV_THRESHOLD: begin
                    c_d.rsp_data = c_q.ov_threshold;
                    if (l_q.write) c_d.ov_threshold = l_q.wdata;
                end
                CMD_OV_RESPONSE: begin
                    c_d.rsp_data = {8'h00, c_q.ov_response};
                    if (l_q.write) c_d.ov_response = l_q.wdata[7:0];
                end
                CMD_UV_THRESHOLD: begin
                    c_d.rsp_data = c_q.uv_threshold;
                    if (l_q.write) c_d.uv_threshold = l_q.wdata;
                end
                CMD_UV_RESPONSE: begin
                    c_d.rsp_data = {8'h00, c_q.uv_response};
                    if (l_q.write) c_d.uv_response = l_q.wdata[7:0];
                end
                default: c_d.rsp_nack = 1'b1;
            endcase
        end
        // OV condition holds between samples, UV is cleared while the output is off or ramping; nothing is judged before thresholds exist
        if (c_q.init_done && vout_meas_valid_i) begin
            c_d.ov_cond = vout_meas_i > c_q.ov_threshold;
            c_d.uv_cond = vout_meas_i < c_q.uv_threshold;
        end
        if (!c_q.out_on || ramping_i) begin
            c_d.uv_cond = 1'b0;
        end
        // Clear first, so a fault present in the same cycle sets the flag again
        if (clear_faults) begin
            c_d.ov_flag = 1'b0;
            c_d.uv_flag = 1'b0;
        end
        if (c_q.ov_cond) c_d.ov_flag = 1'b1;
        if (c_q.uv_cond) c_d.uv_flag = 1'b1;
        c_d.out_on = c_q.init_done && enable_i && !ov_off && !uv_off;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            c_q <= '{
                sense_gain: SENSE_GAIN_RST,
                sense_offset: SENSE_OFFSET_RST,
                ov_threshold: THRESHOLD_RST,
                ov_response: RESPONSE_RST,
                uv_threshold: THRESHOLD_RST,
                uv_response: RESPONSE_RST,
                default: '0
            };
        end else if (ce_i) begin
            c_q <= c_d;
        end
    end

    assign output_on_o = c_q.out_on;
    assign ov_fault_o = c_q.ov_flag;
    assign uv_fault_o = c_q.uv_flag;
    assign sense_gain_o = c_q.sense_gain;
    assign sense_offset_o = c_q.sense_offset;

endmodule // output_fault_limit_response

//--- bench/fault_limit_monitor.sv
// Port-level checks for the output fault limit and response block
`timescale 1ns/10ps
module fault_limit_monitor (
    // Clocks and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire logic cmd_busy_o,
    input wire logic cmd_done_o,
    input wire logic cmd_nack_o,
    input wire logic [15:0] cmd_rdata_o,
    // Converter side
    input wire logic vout_meas_valid_i,
    input wire logic enable_i,
    input wire logic ramping_i,
    input wire logic output_on_o,
    input wire logic ov_fault_o,
    input wire logic uv_fault_o,
    input wire logic [15:0] sense_gain_o,
    input wire logic [15:0] sense_offset_o
);
    ////////////////////////////////////////////////////////////
    // Command handshake, link domain
    sequence take_s;
        cmd_valid_i && !cmd_busy_o;
    endsequence
    sequence answer_s;
        cmd_busy_o ##[0:40] cmd_done_o;
    endsequence
    chk_take_answer: assert property (@(posedge link_clk_i) disable iff (rst_i)
        take_s |=> answer_s) else $error("request not answered in time");
    chk_done_pulse: assert property (@(posedge link_clk_i) disable iff (rst_i)
        cmd_done_o |=> !cmd_done_o) else $error("done longer than one cycle");
    chk_busy_done: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $fell(cmd_busy_o) |-> cmd_done_o) else $error("busy dropped without done");
    chk_answer_held: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $changed(cmd_rdata_o) || $changed(cmd_nack_o) |-> cmd_done_o)
        else $error("answer changed outside done");
    ////////////////////////////////////////////////////////////
    // Registers and fault path, core domain
    chk_gain_by_cmd: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $changed(sense_gain_o) |-> cmd_busy_o) else $error("gain changed with no command");
    chk_offset_by_cmd: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $changed(sense_offset_o) |-> cmd_busy_o) else $error("offset changed with no command");
    chk_ov_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(ov_fault_o) |-> $past(vout_meas_valid_i, 2) || $past(vout_meas_valid_i, 3))
        else $error("ov flag rose without a sample");
    chk_uv_masked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(uv_fault_o) |-> !$past(ramping_i, 2) && $past(output_on_o, 2))
        else $error("uv flag rose while masked");
    chk_off_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !enable_i [*3] |-> !output_on_o) else $error("output on while disabled");
endmodule // fault_limit_monitor

//--- bench/pmbus_host_model.sv
// Host side of the command port: one request at a time, prompt or slow
`timescale 1ns/10ps
module pmbus_host_model (
    // Link clock and answer
    input wire logic link_clk_i,
    input wire logic busy_i,
    input wire logic done_i,
    input wire logic nack_i,
    input wire logic [15:0] rdata_i,
    // Request
    output logic valid_o,
    output logic write_o,
    output logic [7:0] code_o,
    output logic [15:0] wdata_o
);
    initial begin
        valid_o = 1'b0;
        write_o = 1'b0;
        code_o = 8'h00;
        wdata_o = 16'h0000;
    end
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wd,
        output logic [15:0] rd, output logic nk);
        int n;
        rd = 16'hxxxx;
        nk = 1'bx;
        n = 0;
        repeat (1 + $urandom_range(3)) @(posedge link_clk_i);
        valid_o <= 1'b1;
        write_o <= wr;
        code_o <= code;
        wdata_o <= wd;
        // Request stands until an edge finds the port free
        do begin
            @(posedge link_clk_i);
            n++;
        end while (busy_i !== 1'b0 && n < 100);
        valid_o <= 1'b0;
        code_o <= ~code;
        wdata_o <= ~wd;
        do begin
            @(posedge link_clk_i);
            n++;
        end while (done_i !== 1'b1 && n < 200);
        if (done_i === 1'b1) begin
            rd = rdata_i;
            nk = nack_i;
        end
    endtask
endmodule // pmbus_host_model

//--- bench/output_fault_limit_response_test.sv
// Self-checking bench for the output fault limit and response block
`timescale 1ns/10ps
module output_fault_limit_response_test;
    import fault_limit_pkg::*;
    logic ref_clk_i = 0, rst_i = 1, link_clk_i = 0, enable_i = 0, ramping_i = 0, mvalid = 0;
    logic valid, wr, busy, done, nack, on, ovf, uvf, nk, ce = 1;
    logic [7:0] code;
    logic [15:0] wdata, rdata, gain, offs, rd, d, meas = 16'h1800, target = 16'h1000;
    logic [7:0] words [4] = '{CMD_SENSE_GAIN, CMD_SENSE_OFFSET, CMD_OV_THRESHOLD, CMD_UV_THRESHOLD};
    int err_count = 0, n_tests = 0, cycles = 0, n;

    always #5 ref_clk_i = ~ref_clk_i;
    initial begin
        #1.7;
        forever #3 link_clk_i = ~link_clk_i;
    end

    output_fault_limit_response dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .link_clk_i(link_clk_i),
        .cmd_valid_i(valid), .cmd_write_i(wr), .cmd_code_i(code), .cmd_wdata_i(wdata),
        .cmd_busy_o(busy), .cmd_done_o(done), .cmd_nack_o(nack), .cmd_rdata_o(rdata),
        .vout_target_i(target), .vout_meas_i(meas), .vout_meas_valid_i(mvalid),
        .enable_i(enable_i), .ramping_i(ramping_i), .output_on_o(on), .ov_fault_o(ovf),
        .uv_fault_o(uvf), .sense_gain_o(gain), .sense_offset_o(offs));
    pmbus_host_model host (
        .link_clk_i(link_clk_i), .busy_i(busy), .done_i(done), .nack_i(nack),
        .rdata_i(rdata), .valid_o(valid), .write_o(wr), .code_o(code), .wdata_o(wdata));

    ////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] scaled(input logic [15:0] t, input logic [10:0] k);
        logic [26:0] p;
        p = (27'(t) * 27'(k)) >> SCALE_SHIFT;
        return (p > 27'h00_ffff) ? 16'hffff : p[15:0];
    endfunction
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] v);
        host.access(w, c, v, rd, nk);
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge ref_clk_i);
        meas <= v;
        mvalid <= 1;
        @(posedge ref_clk_i);
        mvalid <= 0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // Dropping enable is the only way out of a latched shutdown
    task automatic restart(input logic [7:0] resp);
        cmd(1, CMD_OV_RESPONSE, {8'h00, resp});
        pulse(16'h1800);
        enable_i <= 0;
        repeat (4) @(posedge ref_clk_i);
        enable_i <= 1;
        cmd(1, CMD_CLEAR_FAULTS, 0);
        repeat (4) @(posedge ref_clk_i);
    endtask
    task automatic wait_on(input logic v, input int lim);
        n = 0;
        while (on !== v && n < lim) begin
            @(posedge ref_clk_i);
            n++;
        end
    endtask

    // Ceiling far above the few thousand cycles the sequence needs
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(8));
        target = 16'h1000 + 16'($urandom_range(16'h3fff));
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 0;
        repeat (6) @(posedge ref_clk_i);
        check("gain", SENSE_GAIN_RST, gain);
        check("offset", SENSE_OFFSET_RST, offs);
        cmd(0, CMD_OV_RESPONSE, 0);
        check("ov response", 16'h0080, rd);
        cmd(0, CMD_UV_RESPONSE, 0);
        check("uv response", 16'h0080, rd);
        cmd(0, CMD_OV_THRESHOLD, 0);
        check("ov threshold", scaled(target, OV_SCALE), rd);
        cmd(0, CMD_UV_THRESHOLD, 0);
        check("uv threshold", scaled(target, UV_SCALE), rd);
        foreach (words[i]) begin
            d = 16'($urandom);
            cmd(1, words[i], d);
            cmd(0, words[i], 0);
            check("word readback", d, rd);
        end
        cmd(1, CMD_SENSE_OFFSET, 16'h5a5a);
        check("offset port", 16'h5a5a, offs);
        cmd(1, 8'h55, 16'h1234);
        check("unknown nack", 1, nk);
        cmd(1, CMD_UV_RESPONSE, 16'hff80);
        check("byte write old", 16'h0080, rd);
        cmd(0, CMD_UV_RESPONSE, 0);
        check("byte write upper", 16'h0080, rd);
        cmd(1, CMD_OV_THRESHOLD, 16'h2000);
        cmd(1, CMD_UV_THRESHOLD, 16'h1000);
        restart(8'h00);
        pulse(16'h2100);
        check("ov flag", 1, ovf);
        check("ov ignore refused", 0, on);
        pulse(16'h1800);
        repeat (300) @(posedge ref_clk_i);
        check("stays off", 0, on);
        // An enable drop that the frozen core never sees must not restart it
        ce <= 0;
        enable_i <= 0;
        repeat (4) @(posedge ref_clk_i);
        enable_i <= 1;
        ce <= 1;
        repeat (4) @(posedge ref_clk_i);
        check("frozen restart", 0, on);
        cmd(0, CMD_CLEAR_FAULTS, 0);
        check("flag cleared", 0, ovf);
        check("no restart", 0, on);
        restart(8'h8a);
        pulse(16'h2100);
        check("off at once", 0, on);
        pulse(16'h1800);
        wait_on(1, 400);
        check("retry spacing", 1, n > 80 && n < 220);
        pulse(16'h2100);
        wait_on(1, 500);
        check("retries spent", 0, on);
        restart(8'h42);
        pulse(16'h2100);
        repeat (80) @(posedge ref_clk_i);
        check("delay keeps on", 1, on);
        wait_on(0, 300);
        check("delayed off", 0, on);
        restart(8'hc0);
        pulse(16'h2100);
        check("hold off", 0, on);
        pulse(16'h1800);
        check("hold released", 1, on);
        restart(8'hb9);
        pulse(16'h2100);
        repeat (3) begin
            wait_on(1, 300);
            check("endless retry", 1, on);
            wait_on(0, 10);
        end
        cmd(1, CMD_CLEAR_FAULTS, 0);
        check("flag reasserts", 1, ovf);
        restart(8'h80);
        cmd(1, CMD_UV_RESPONSE, 16'h0000);
        pulse(16'h0800);
        check("uv flag", 1, uvf);
        check("uv ignored", 1, on);
        cmd(1, CMD_UV_RESPONSE, 16'h0080);
        pulse(16'h1800);
        cmd(1, CMD_CLEAR_FAULTS, 0);
        @(posedge ref_clk_i);
        ramping_i <= 1;
        pulse(16'h0800);
        check("uv masked", 0, uvf);
        ramping_i <= 0;
        pulse(16'h0800);
        check("uv shutdown", 0, on);
        cmd(0, CMD_CLEAR_FAULTS, 0);
        check("uv clear off", 0, uvf);
        check("no uv restart", 0, on);
        end_of_test();
    end
endmodule // output_fault_limit_response_test

bind output_fault_limit_response fault_limit_monitor mon (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .cmd_valid_i(cmd_valid_i), .cmd_busy_o(cmd_busy_o), .cmd_done_o(cmd_done_o),
    .cmd_nack_o(cmd_nack_o), .cmd_rdata_o(cmd_rdata_o), .enable_i(enable_i),
    .vout_meas_valid_i(vout_meas_valid_i), .ramping_i(ramping_i), .output_on_o(output_on_o),
    .ov_fault_o(ov_fault_o), .uv_fault_o(uv_fault_o), .sense_gain_o(sense_gain_o),
    .sense_offset_o(sense_offset_o));
